// >>> hdl/ppp_consts.svh
`ifndef PPP_CONSTS_SVH
`define PPP_CONSTS_SVH
`define PPP_FLASH_WORDS     1024
`define PPP_FLASH_PAGE_W    16
`define PPP_EE_BYTES        128
`define PPP_EE_PAGE_B       4
`define PPP_ACT_ADDR        2'h0
`define PPP_ACT_DATA        2'h1
`define PPP_ACT_CMD         2'h2
`define PPP_ACT_IDLE        2'h3
`define PPP_CMD_NOP         8'h00
`define PPP_CMD_ERASE       8'h80
`define PPP_CMD_WR_FUSE     8'h40
`define PPP_CMD_WR_LOCK     8'h20
`define PPP_CMD_WR_FLASH    8'h10
`define PPP_CMD_WR_EE       8'h11
`define PPP_CMD_RD_SIG      8'h08
`define PPP_CMD_RD_FUSE     8'h04
`define PPP_CMD_RD_FLASH    8'h02
`define PPP_CMD_RD_EE       8'h03
`define PPP_FUSE_LO_RST     8'he1
`define PPP_FUSE_HI_RST     8'hf7
`define PPP_LOCK_RST        8'hff
`define PPP_KEEP_EE_BIT     2
`define PPP_WRITE_MS        4
`define PPP_ERASE_MS        8
`define PPP_CLK_MHZ         40
`endif

// >>> hdl/ppp_pkg.sv
package ppp_pkg;
    typedef enum logic [1:0] {
        PPP_IDLE  = 2'b00,
        PPP_BUSY  = 2'b01,
        PPP_CLEAR = 2'b10
    } ppp_state_t;
    typedef enum logic [1:0] {
        PPP_OP_NONE  = 2'b00,
        PPP_OP_FLASH = 2'b01,
        PPP_OP_EE    = 2'b10,
        PPP_OP_ERASE = 2'b11
    } ppp_op_t;
endpackage : ppp_pkg

// >>> hdl/ppp_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ppp_mem
    import ppp_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 1024
) (
    input  wire logic                     clk,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [WIDTH-1:0]         rdata
);
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
        $error("ppp_mem bad size");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule : ppp_mem
`default_nettype wire

// >>> hdl/ppp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ppp_sync
    import ppp_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    if (WIDTH < 1) begin : g_bad_width
        $error("ppp_sync bad width");
    end
    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : ppp_sync
`default_nettype wire

// >>> hdl/ppp_port.sv
// Behaviour
// - Flash is 64 pages of 16 words; address 3:0 word, 9:4 page.
// - EEPROM 128 bytes, 32 pages of 4; address 1:0 byte in page.
// - Load strobe rising acts on action select: address, data, command, idle.
// - Byte select picks low or high byte for address and flash data.
// - Holding registers change only on a load strobe pulse.
// - Command bytes decode to erase, fuse, lock, flash, EEPROM, read operations.
// - Write strobe or output enable performs the last loaded command.
// - Ready/busy low while programming, high when ready.
// - Data bus driven only while output enable is low.
// - Command and address are kept across programming operations.
// - Chip erase clears flash, EEPROM, locks; fuses kept; locks last.
// - Keep-EEPROM fuse programmed leaves EEPROM intact on erase.
// - Flash data bytes latch into a page buffer at the addressed word.
// - Lower address bits pick the word, upper bits pick the page.
// - Write pulse with byte select low programs buffered page, busy low.
// - No-operation command ends page programming and clears write signals.
// - EEPROM page writes load address low and data, then a write pulse.
`timescale 1ns/10ps
`default_nettype none
`include "ppp_consts.svh"
module ppp_port
    import ppp_pkg::*;
#(
    parameter int WRITE_CYCLES = `PPP_WRITE_MS * 1000 * `PPP_CLK_MHZ,
    parameter int ERASE_CYCLES = `PPP_ERASE_MS * 1000 * `PPP_CLK_MHZ
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       link_clk,
    input  wire logic       load_strobe,
    input  wire logic       action_select_bit0,
    input  wire logic       action_select_bit1,
    input  wire logic       byte_select_lo_hi,
    input  wire logic       write_n,
    input  wire logic       output_enable_n,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic            ready_busy_flag,
    output logic            lock_release
);
    localparam int FA_W = $clog2(`PPP_FLASH_WORDS);
    localparam int FW_W = $clog2(`PPP_FLASH_PAGE_W);
    localparam int EA_W = $clog2(`PPP_EE_BYTES);
    localparam int EW_W = $clog2(`PPP_EE_PAGE_B);
    if (WRITE_CYCLES < 2 || ERASE_CYCLES < 2) begin : g_bad_counts
        $error("ppp_port counts too small");
    end
    // Pins sampled twice in the system domain; active-low pins are inverted first
    // so that a cleared synchroniser reads as idle and no false edge follows reset
    logic [13:0] pins_raw;
    logic [13:0] pins_s;
    logic [13:0] pins_q;
    // Load strobe is first taken on the link clock, then crossed as a slow level
    logic ls_lk1;
    logic ls_lk2;
    always_ff @(posedge link_clk) begin
        ls_lk1 <= load_strobe;
        ls_lk2 <= ls_lk1;
    end
    assign pins_raw = {ls_lk2, ~write_n, ~output_enable_n,
                       action_select_bit1, action_select_bit0,
                       byte_select_lo_hi, data_in[7:0]};
    ppp_sync #(.WIDTH(14)) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pins_q <= 14'h0000;
        end else begin
            pins_q <= pins_s;
        end
    end
    logic       load_rise;
    logic       write_fall;
    logic       oe_low;
    logic [1:0] action;
    logic       bsel;
    logic [7:0] dbus;
    assign load_rise  = pins_s[13] && !pins_q[13];
    assign write_fall = pins_s[12] && !pins_q[12];
    assign oe_low     = pins_s[11];
    assign action     = pins_s[10:9];
    assign bsel       = pins_s[8];
    assign dbus       = pins_s[7:0];
    // Holding registers
    logic [7:0]  cmd;
    logic [7:0]  addr_lo;
    logic [7:0]  addr_hi;
    logic [7:0]  dat_lo;
    logic [7:0]  fuse_lo;
    logic [7:0]  fuse_hi;
    logic [7:0]  lock_bits;
    ppp_state_t  state;
    ppp_op_t     op;
    logic [31:0] timer;
    logic        page_wr_en;
    logic [FA_W-1:0] clr_addr;
    function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] k);
        return c == k;
    endfunction : is_cmd
    logic busy;
    assign busy = state != PPP_IDLE;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd <= `PPP_CMD_NOP;
        end else if (load_rise && action == `PPP_ACT_CMD) begin
            cmd <= dbus;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
        end else if (load_rise && action == `PPP_ACT_ADDR) begin
            if (bsel) begin
                addr_hi <= dbus;
            end else begin
                addr_lo <= dbus;
            end
        end
    end
    // Data loads; high flash byte completes a word into the page buffer
    logic              buf_we;
    logic [FW_W-1:0]   buf_waddr;
    logic [15:0]       buf_wdata;
    logic              ebuf_we;
    logic [7:0]        ebuf [`PPP_EE_PAGE_B];
    logic              data_load;
    assign data_load = load_rise && action == `PPP_ACT_DATA;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dat_lo <= 8'h00;
        end else if (data_load && !bsel) begin
            dat_lo <= dbus;
        end
    end
    assign buf_we    = data_load && bsel && is_cmd(cmd, `PPP_CMD_WR_FLASH);
    assign buf_waddr = addr_lo[FW_W-1:0];
    assign buf_wdata = {dbus, dat_lo};
    assign ebuf_we   = data_load && is_cmd(cmd, `PPP_CMD_WR_EE);
    always_ff @(posedge clk) begin
        if (ebuf_we) begin
            ebuf[addr_lo[EW_W-1:0]] <= dbus;
        end
    end
    logic [15:0] pbuf [`PPP_FLASH_PAGE_W];
    always_ff @(posedge clk) begin
        if (buf_we) begin
            pbuf[buf_waddr] <= buf_wdata;
        end
    end
    // Programming engine
    logic [FA_W-1:0] page_base;
    logic [FW_W-1:0] copy_idx;
    logic            fl_we;
    logic [FA_W-1:0] fl_waddr;
    logic [15:0]     fl_wdata;
    logic            ee_we;
    logic [EA_W-1:0] ee_waddr;
    logic [7:0]      ee_wdata;
    logic            keep_ee;
    assign page_base = {addr_hi[1:0], addr_lo[7:FW_W], {FW_W{1'b0}}};
    assign keep_ee   = !fuse_hi[`PPP_KEEP_EE_BIT];
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state    <= PPP_IDLE;
            op       <= PPP_OP_NONE;
            timer    <= 32'h0;
            clr_addr <= '0;
            copy_idx <= '0;
        end else begin
            case (state)
                PPP_IDLE: begin
                    if (write_fall && !bsel) begin
                        if (is_cmd(cmd, `PPP_CMD_ERASE)) begin
                            op       <= PPP_OP_ERASE;
                            state    <= PPP_CLEAR;
                            clr_addr <= '0;
                            timer    <= 32'(ERASE_CYCLES);
                        end else if (is_cmd(cmd, `PPP_CMD_WR_FLASH) && page_wr_en) begin
                            op       <= PPP_OP_FLASH;
                            state    <= PPP_CLEAR;
                            copy_idx <= '0;
                            timer    <= 32'(WRITE_CYCLES);
                        end else if (is_cmd(cmd, `PPP_CMD_WR_EE) && page_wr_en) begin
                            op       <= PPP_OP_EE;
                            state    <= PPP_CLEAR;
                            copy_idx <= '0;
                            timer    <= 32'(WRITE_CYCLES);
                        end
                    end
                    if (write_fall && (is_cmd(cmd, `PPP_CMD_WR_FUSE)
                                       || is_cmd(cmd, `PPP_CMD_WR_LOCK))) begin
                        op    <= PPP_OP_NONE;
                        state <= PPP_BUSY;
                        timer <= 32'(WRITE_CYCLES);
                    end
                end
                PPP_CLEAR: begin
                    // Timer starts once the copy or sweep is over
                    clr_addr <= clr_addr + 1'b1;
                    copy_idx <= copy_idx + 1'b1;
                    if ((op == PPP_OP_ERASE && &clr_addr) ||
                        (op != PPP_OP_ERASE && &copy_idx)) begin
                        state <= PPP_BUSY;
                    end
                end
                PPP_BUSY: begin
                    timer <= timer - 32'h1;
                    if (timer <= 32'h1) begin
                        state <= PPP_IDLE;
                    end
                end
                default: state <= PPP_IDLE;
            endcase
        end
    end
    // Page writes are armed by a write command and cleared by no-operation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            page_wr_en <= 1'b0;
        end else if (load_rise && action == `PPP_ACT_CMD) begin
            page_wr_en <= dbus == `PPP_CMD_WR_FLASH || dbus == `PPP_CMD_WR_EE;
        end
    end
    logic erase_on;
    assign erase_on = state == PPP_CLEAR && op == PPP_OP_ERASE;
    assign fl_we    = state == PPP_CLEAR && op != PPP_OP_EE;
    assign fl_waddr = erase_on ? clr_addr : (page_base | FA_W'(copy_idx));
    assign fl_wdata = erase_on ? 16'hffff : pbuf[copy_idx];
    assign ee_we    = state == PPP_CLEAR && ((op == PPP_OP_EE && copy_idx < FW_W'(`PPP_EE_PAGE_B))
                      || (erase_on && !keep_ee && clr_addr < FA_W'(`PPP_EE_BYTES)));
    assign ee_waddr = erase_on ? clr_addr[EA_W-1:0]
                      : {addr_lo[EA_W-1:EW_W], copy_idx[EW_W-1:0]};
    assign ee_wdata = erase_on ? 8'hff : ebuf[copy_idx[EW_W-1:0]];
    // Fuses are kept by erase; locks released only once the flash sweep is done
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fuse_lo   <= `PPP_FUSE_LO_RST;
            fuse_hi   <= `PPP_FUSE_HI_RST;
            lock_bits <= `PPP_LOCK_RST;
        end else begin
            if (erase_on && &clr_addr) begin
                lock_bits <= `PPP_LOCK_RST;
            end else if (state == PPP_IDLE && write_fall && is_cmd(cmd, `PPP_CMD_WR_LOCK)) begin
                lock_bits <= lock_bits & dat_lo;
            end
            if (state == PPP_IDLE && write_fall && is_cmd(cmd, `PPP_CMD_WR_FUSE)
                && lock_bits[0]) begin
                if (bsel) begin
                    fuse_hi <= dat_lo;
                end else begin
                    fuse_lo <= dat_lo;
                end
            end
        end
    end
    assign lock_release = &lock_bits[1:0];
    // Memories
    logic [15:0] fl_rdata;
    logic [7:0]  ee_rdata;
    ppp_mem #(.WIDTH(16), .DEPTH(`PPP_FLASH_WORDS)) u_flash (
        .clk   (clk),
        .we    (fl_we),
        .waddr (fl_waddr),
        .wdata (fl_wdata),
        .raddr ({addr_hi[1:0], addr_lo}),
        .rdata (fl_rdata)
    );
    ppp_mem #(.WIDTH(8), .DEPTH(`PPP_EE_BYTES)) u_ee (
        .clk   (clk),
        .we    (ee_we),
        .waddr (ee_waddr),
        .wdata (ee_wdata),
        .raddr (addr_lo[EA_W-1:0]),
        .rdata (ee_rdata)
    );
    // Read data; bus driven only with output enable low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_out <= 8'h00;
        end else if (oe_low) begin
            case (cmd)
                `PPP_CMD_RD_FLASH: data_out <= bsel ? fl_rdata[15:8] : fl_rdata[7:0];
                `PPP_CMD_RD_EE:    data_out <= ee_rdata;
                `PPP_CMD_RD_FUSE:  data_out <= bsel ? (action[1] ? fuse_hi : lock_bits)
                                                    : fuse_lo;
                default:           data_out <= 8'hff;
            endcase
        end
    end
    assign data_oe         = oe_low;
    assign ready_busy_flag = !busy;
    a_busy_after_wr: assert property (@(posedge clk) disable iff (sys_rst)
        (state == PPP_IDLE && write_fall && !bsel && is_cmd(cmd, `PPP_CMD_ERASE))
        |=> !ready_busy_flag) else $error("busy not raised by erase");
    a_page_busy: assert property (@(posedge clk) disable iff (sys_rst)
        (state == PPP_IDLE && write_fall && !bsel && page_wr_en
         && is_cmd(cmd, `PPP_CMD_WR_FLASH)) |=> !ready_busy_flag)
        else $error("busy not raised by page write");
    a_cmd_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !load_rise |=> $stable(cmd)) else $error("command changed without load");
    a_addr_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !load_rise |=> $stable(addr_lo) && $stable(addr_hi))
        else $error("address changed without load");
    a_data_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !load_rise |=> $stable(dat_lo)) else $error("data changed without load");
    a_cmd_load: assert property (@(posedge clk) disable iff (sys_rst)
        (load_rise && action == `PPP_ACT_CMD) |=> cmd == $past(dbus))
        else $error("command not loaded");
    a_oe_drive: assert property (@(posedge clk) disable iff (sys_rst)
        data_oe |-> $past(!output_enable_n, 2))
        else $error("bus driven with output enable high");
    a_nop_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (load_rise && action == `PPP_ACT_CMD && dbus == `PPP_CMD_NOP) |=> !page_wr_en)
        else $error("write signals not cleared");
    a_fuse_keep: assert property (@(posedge clk) disable iff (sys_rst)
        erase_on |=> $stable(fuse_lo) && $stable(fuse_hi))
        else $error("erase altered fuses");
    a_lock_last: assert property (@(posedge clk) disable iff (sys_rst)
        (erase_on && !(&clr_addr)) |=> $stable(lock_bits))
        else $error("locks released before sweep end");
    a_lock_free: assert property (@(posedge clk) disable iff (sys_rst)
        (erase_on && &clr_addr) |=> lock_release) else $error("locks kept after erase");
    a_ee_keep: assert property (@(posedge clk) disable iff (sys_rst)
        (erase_on && keep_ee) |-> !ee_we) else $error("erase touched kept eeprom");
    a_busy_ends: assert property (@(posedge clk) disable iff (sys_rst)
        (state == PPP_BUSY && timer == 32'h1) |=> ready_busy_flag)
        else $error("ready not restored");
endmodule : ppp_port
`default_nettype wire

// >>> tb/ppp_prog.sv
`timescale 1ns/10ps
`default_nettype none
module ppp_prog (
    input  wire logic       clk,
    input  wire logic [7:0] bus,
    input  wire logic       ready_busy_flag,
    output var logic        load_strobe,
    output var logic        action_select_bit0,
    output var logic        action_select_bit1,
    output var logic        byte_select_lo_hi,
    output var logic        write_n,
    output var logic        output_enable_n,
    output var logic [7:0]  drv
);
    // Entry pattern pins low; supply and high-voltage sequencing is not modelled
    initial begin
        load_strobe        = 1'b0;
        action_select_bit0 = 1'b0;
        action_select_bit1 = 1'b0;
        byte_select_lo_hi  = 1'b0;
        write_n            = 1'b1;
        output_enable_n    = 1'b1;
        drv                = 8'h00;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold

    // Levels held well around the strobe, since the device samples through flops
    task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] val);
        action_select_bit1 <= act[1];
        action_select_bit0 <= act[0];
        byte_select_lo_hi  <= bs;
        drv                <= val;
        hold(4);
        load_strobe <= 1'b1;
        hold(6);
        load_strobe <= 1'b0;
        hold(4);
        // Released value is inverted so a stale bus never looks right
        drv <= ~val;
        hold(1);
    endtask : load

    task automatic wpulse(input logic bs);
        byte_select_lo_hi <= bs;
        hold(4);
        write_n <= 1'b0;
        hold(6);
        write_n <= 1'b1;
        hold(4);
    endtask : wpulse

    // Second byte select is action select bit 1, which command and idle loads also raise with the load strobe
    task automatic rd(input logic bs2, input logic bs1, output logic [7:0] val);
        action_select_bit1 <= bs2;
        byte_select_lo_hi  <= bs1;
        hold(4);
        output_enable_n <= 1'b0;
        hold(10);
        val = bus;
        output_enable_n <= 1'b1;
        hold(6);
    endtask : rd

    // Nothing new is started until the device is ready again
    task automatic wait_ready(output logic ok);
        int n;
        n = 0;
        while (ready_busy_flag !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        ok = (ready_busy_flag === 1'b1);
        hold(2);
    endtask : wait_ready
endmodule : ppp_prog
`default_nettype wire

// >>> tb/tb_parallel_program_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "ppp_consts.svh"
module tb_parallel_program_port;
    import ppp_pkg::*;
    logic        clk;
    logic        sys_rst;
    logic        link_clk;
    logic        load_strobe;
    logic        action_select_bit0;
    logic        action_select_bit1;
    logic        byte_select_lo_hi;
    logic        write_n;
    logic        output_enable_n;
    logic [7:0]  drv;
    logic [7:0]  bus;
    logic [7:0]  data_out;
    logic        data_oe;
    logic        ready_busy_flag;
    logic        lock_release;
    logic [15:0] fm [int];
    logic [7:0]  em [int];
    logic [7:0]  fuse_hi;
    logic [7:0]  b;
    logic        ok;
    int          n_fail;
    int          checks_done;

    assign bus = (data_oe === 1'b1) ? data_out : drv;

    // Short busy counts keep the run small
    ppp_port #(.WRITE_CYCLES(20), .ERASE_CYCLES(40)) ppp_port_i (
        .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .load_strobe(load_strobe),
        .action_select_bit0(action_select_bit0), .action_select_bit1(action_select_bit1),
        .byte_select_lo_hi(byte_select_lo_hi), .write_n(write_n),
        .output_enable_n(output_enable_n), .data_in(bus), .data_out(data_out),
        .data_oe(data_oe), .ready_busy_flag(ready_busy_flag), .lock_release(lock_release));

    ppp_prog ppp_prog_i (
        .clk(link_clk), .bus(bus), .ready_busy_flag(ready_busy_flag), .load_strobe(load_strobe),
        .action_select_bit0(action_select_bit0), .action_select_bit1(action_select_bit1),
        .byte_select_lo_hi(byte_select_lo_hi), .write_n(write_n),
        .output_enable_n(output_enable_n), .drv(drv));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    task automatic wrap_up();
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask : chk1

    task automatic cmd(input logic [7:0] c);
        ppp_prog_i.load(`PPP_ACT_CMD, 1'b0, c);
    endtask : cmd

    task automatic settle();
        ppp_prog_i.wait_ready(ok);
        chk1(ok, 1'b1);
        if (ok !== 1'b1) wrap_up();
    endtask : settle

    task automatic erase();
        cmd(`PPP_CMD_ERASE);
        ppp_prog_i.wpulse(1'b0);
        chk1(ready_busy_flag, 1'b0);
        settle();
        fm.delete();
        if (fuse_hi[`PPP_KEEP_EE_BIT]) em.delete();
    endtask : erase

    task automatic rd_flash(input int a);
        logic [15:0] e;
        e = fm.exists(a) ? fm[a] : 16'hffff;
        ppp_prog_i.load(`PPP_ACT_ADDR, 1'b1, 8'(a >> 8));
        ppp_prog_i.load(`PPP_ACT_ADDR, 1'b0, 8'(a));
        ppp_prog_i.rd(1'b0, 1'b0, b);
        chk8(b, e[7:0]);
        ppp_prog_i.rd(1'b0, 1'b1, b);
        chk8(b, e[15:8]);
    endtask : rd_flash

    task automatic rd_ee(input int a);
        ppp_prog_i.load(`PPP_ACT_ADDR, 1'b0, 8'(a));
        ppp_prog_i.rd(1'b0, 1'b0, b);
        chk8(b, em.exists(a) ? em[a] : 8'hff);
    endtask : rd_ee

    initial begin : main
        int          page;
        int          a;
        logic [15:0] w;
        n_fail = 0;
        checks_done = 0;
        fuse_hi = `PPP_FUSE_HI_RST;
        sys_rst = 1'b1;
        void'($urandom(32'hb79d));
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk1(ready_busy_flag, 1'b1);
        chk1(data_oe, 1'b0);
        erase();
        cmd(`PPP_CMD_RD_EE);
        rd_ee(5);
        // One command load serves the whole page
        cmd(`PPP_CMD_WR_FLASH);
        page = $urandom_range(63);
        for (int k = 0; k < 16; k += 5) begin
            a = page * 16 + k;
            w = 16'($urandom);
            fm[a] = w;
            ppp_prog_i.load(`PPP_ACT_ADDR, 1'b0, 8'(a));
            ppp_prog_i.load(`PPP_ACT_DATA, 1'b0, w[7:0]);
            ppp_prog_i.load(`PPP_ACT_DATA, 1'b1, w[15:8]);
        end
        ppp_prog_i.load(`PPP_ACT_ADDR, 1'b1, 8'(a >> 8));
        ppp_prog_i.wpulse(1'b0);
        chk1(ready_busy_flag, 1'b0);
        settle();
        cmd(`PPP_CMD_NOP);
        ppp_prog_i.wpulse(1'b0);
        chk1(ready_busy_flag, 1'b1);
        cmd(`PPP_CMD_RD_FLASH);
        for (int k = 0; k < 16; k += 5) rd_flash(page * 16 + k);
        // Idle code with a strobe, then stray select levels, must not move the address
        ppp_prog_i.load(`PPP_ACT_IDLE, 1'b0, 8'h00);
        ppp_prog_i.rd(1'b0, 1'b0, b);
        chk8(b, fm[page * 16 + 15][7:0]);
        rd_flash(((page + 1) % 64) * 16);
        cmd(`PPP_CMD_WR_EE);
        page = $urandom_range(31);
        for (int k = 0; k < 4; k++) begin
            em[page * 4 + k] = 8'($urandom);
            ppp_prog_i.load(`PPP_ACT_ADDR, 1'b0, 8'(page * 4 + k));
            ppp_prog_i.load(`PPP_ACT_DATA, 1'b0, em[page * 4 + k]);
        end
        ppp_prog_i.wpulse(1'b0);
        chk1(ready_busy_flag, 1'b0);
        settle();
        cmd(`PPP_CMD_RD_EE);
        for (int k = 0; k < 4; k++) rd_ee(page * 4 + k);
        cmd(`PPP_CMD_WR_FUSE);
        fuse_hi = 8'hf3;
        ppp_prog_i.load(`PPP_ACT_DATA, 1'b0, fuse_hi);
        ppp_prog_i.wpulse(1'b1);
        settle();
        cmd(`PPP_CMD_RD_FUSE);
        ppp_prog_i.rd(1'b1, 1'b1, b);
        chk8(b, fuse_hi);
        ppp_prog_i.rd(1'b0, 1'b0, b);
        chk8(b, `PPP_FUSE_LO_RST);
        ppp_prog_i.rd(1'b0, 1'b1, b);
        chk8(b, 8'hff);
        cmd(`PPP_CMD_WR_LOCK);
        ppp_prog_i.load(`PPP_ACT_DATA, 1'b0, 8'hfc);
        ppp_prog_i.wpulse(1'b0);
        settle();
        chk1(lock_release, 1'b0);
        erase();
        chk1(lock_release, 1'b1);
        cmd(`PPP_CMD_RD_EE);
        rd_ee(page * 4 + 2);
        cmd(`PPP_CMD_RD_FLASH);
        rd_flash(a);
        chk1(data_oe, 1'b0);
        wrap_up();
    end
endmodule : tb_parallel_program_port
`default_nettype wire
